//--- logic/pcmc_pkg.sv
// Behaviour
// [R1] the master clock comes either from dividing the reference or from the loop multiplying it.
// [R2] in multiplier mode the reference is scaled by one of 31 ratios picked by the mode register; the code gives 23 distinct ratios.
// [R3] in divider mode the reference is divided by 2 or 4, and the loop may be switched fully off.
// [R4] one 16-bit clock mode register at address 0058h holds the whole clock setup.
// [R5] on reset the mode register takes a fixed value that depends only on the three strap pins.
// [R6] straps 001, 010, 100 load 9007h, 4007h, 1007h (times 10, 5 and 2).
// [R7] straps 110 load F007h, 101 load F000h, 000 and 111 load 0000h, and 011 is bypass.
// [R8] straps are sampled while device reset is low, and software may rewrite the mode afterwards.
// [R9] a newly started loop acquires lock first and then keeps tracking the reference.
// [R10] a programmable lock timer holds off the switch to multiplier clocking until lock.
// [R11] software turns the loop on or off through the mode register apart from the ratio.
// [R12] switching between divider and loop clocks never cuts a high or low phase short; a switch to divide-by-2 ends the low phase at the next reference rise.
package pcmc_pkg;
    // ====================================================================
    // register map and field layout
    localparam logic [15:0] PCMC_CMR_ADDR = 16'h0058;
    localparam int PCMC_MUL_MSB = 15;
    localparam int PCMC_MUL_LSB = 12;
    localparam int PCMC_HALF_BIT = 11;
    localparam int PCMC_CNT_MSB = 10;
    localparam int PCMC_CNT_LSB = 3;
    localparam int PCMC_ON_BIT = 2;
    localparam int PCMC_MODE_BIT = 1;
    localparam int PCMC_STAT_BIT = 0;
    localparam logic [3:0] PCMC_MUL_DIV4 = 4'hF;
    localparam logic [3:0] PCMC_MUL_ONE = 4'hF;
    // ====================================================================
    // reset values per strap pattern
    localparam logic [15:0] PCMC_RST_X10 = 16'h9007;
    localparam logic [15:0] PCMC_RST_X5 = 16'h4007;
    localparam logic [15:0] PCMC_RST_X2 = 16'h1007;
    localparam logic [15:0] PCMC_RST_X1 = 16'hF007;
    localparam logic [15:0] PCMC_RST_DIV4 = 16'hF000;
    localparam logic [15:0] PCMC_RST_DIV2 = 16'h0000;
    localparam logic [2:0] PCMC_STRAP_BYPASS = 3'h3;
    // ====================================================================
    // timing: lock timer ticks once per prescale period of mclk
    localparam logic [3:0] PCMC_LOCK_PRESCALE_LAST = 4'hF;
    // ====================================================================
    // types
    typedef enum logic [1:0] {
        PCMC_SRC_DIV = 2'b00,
        PCMC_SRC_PLL = 2'b01,
        PCMC_SRC_BYP = 2'b10
    } pcmc_src_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pcmc_bus_req_s;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } pcmc_strap_s;
endpackage

//--- logic/pcmc_clock_gen.sv
`timescale 1ns/1ps
module pcmc_clock_gen (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic device_reset_n,
    input wire pcmc_pkg::pcmc_strap_s mode_strap,
    input wire logic reference_clock_input,
    input wire pcmc_pkg::pcmc_bus_req_s bus_req,
    output logic [15:0] bus_rdata,
    output logic master_clock_output,
    output logic pll_locked
);
    // ====================================================================
    // state
    typedef struct packed {
        logic [15:0] clock_mode_reg;
        logic [15:0] rdata;
        logic ref_q;
        logic [15:0] period_cnt;
        logic [15:0] period;
        logic stable;
        logic [3:0] prescale;
        logic [7:0] lock_cnt;
        logic locked;
        logic [17:0] acc;
        logic div_phase;
        logic out;
        pcmc_pkg::pcmc_src_e src;
        logic bypass;
        logic init_pending;
    } pcmc_state_s;

    pcmc_state_s st_reg;
    pcmc_state_s st_next;

    // strap pattern to mode register value
    function automatic logic [15:0] strap_value(input pcmc_pkg::pcmc_strap_s s);
        logic [2:0] p;
        p = {s.a, s.b, s.c};
        unique case (p)
            3'h1: strap_value = pcmc_pkg::PCMC_RST_X10; // [R6]
            3'h2: strap_value = pcmc_pkg::PCMC_RST_X5; // [R6]
            3'h4: strap_value = pcmc_pkg::PCMC_RST_X2; // [R6]
            3'h6: strap_value = pcmc_pkg::PCMC_RST_X1; // [R7]
            3'h5: strap_value = pcmc_pkg::PCMC_RST_DIV4; // [R7]
            default: strap_value = pcmc_pkg::PCMC_RST_DIV2; // [R7]
        endcase
    endfunction

    logic ref_rise;
    logic [3:0] mul_f;
    logic half_f;
    logic pll_on;
    logic pll_mode;
    logic [4:0] num;
    logic [16:0] thr;
    logic [17:0] acc_sum;
    logic pll_tick;
    logic div_tick;
    logic lock_tick;
    logic cmr_hit;
    pcmc_pkg::pcmc_src_e want_src;
    logic [15:0] wval;

    // ====================================================================
    // decoded fields and generator events
    always_comb begin
        ref_rise = reference_clock_input & ~st_reg.ref_q;
        mul_f = st_reg.clock_mode_reg[pcmc_pkg::PCMC_MUL_MSB:pcmc_pkg::PCMC_MUL_LSB];
        half_f = st_reg.clock_mode_reg[pcmc_pkg::PCMC_HALF_BIT];
        pll_on = st_reg.clock_mode_reg[pcmc_pkg::PCMC_ON_BIT];
        pll_mode = st_reg.clock_mode_reg[pcmc_pkg::PCMC_MODE_BIT];
        // numerator 1..16, halved by the half bit: 23 distinct ratios
        if ((mul_f == pcmc_pkg::PCMC_MUL_ONE) && !half_f) begin // [R2]
            num = 5'h01;
        end else begin
            num = {1'b0, mul_f} + 5'h01;
        end
        thr = half_f ? {st_reg.period, 1'b0} : {1'b0, st_reg.period};
        acc_sum = st_reg.acc + {12'h000, num, 1'b0};
        // two edges per output period, so half-period = period*den/(2*num)
        pll_tick = (acc_sum >= {1'b0, thr}); // [R1] [R2]
        div_tick = ref_rise && ((mul_f != pcmc_pkg::PCMC_MUL_DIV4) || st_reg.div_phase); // [R3]
        lock_tick = (st_reg.prescale == pcmc_pkg::PCMC_LOCK_PRESCALE_LAST);
        cmr_hit = (bus_req.addr == pcmc_pkg::PCMC_CMR_ADDR);
        // bypass first; loop clock only once locked, else stay on divider
        if (st_reg.bypass) begin
            want_src = pcmc_pkg::PCMC_SRC_BYP;
        end else if (pll_mode && pll_on && st_reg.locked) begin // [R10]
            want_src = pcmc_pkg::PCMC_SRC_PLL;
        end else begin
            want_src = pcmc_pkg::PCMC_SRC_DIV;
        end
        wval = bus_req.wdata;
    end

    // ====================================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.ref_q = reference_clock_input;
        st_next.prescale = st_reg.prescale + 4'h1;
        // reference period measurement, saturating when the reference stalls
        if (ref_rise) begin // [R9]
            st_next.period = st_reg.period_cnt;
            st_next.stable = (st_reg.period_cnt == st_reg.period) && (st_reg.period_cnt != 16'h0000);
            st_next.period_cnt = 16'h0001;
        end else if (st_reg.period_cnt != 16'hFFFF) begin
            st_next.period_cnt = st_reg.period_cnt + 16'h0001;
        end else begin
            st_next.stable = 1'b0;
        end
        // acquisition then tracking: lock timer must run out with a stable period
        if (!pll_on) begin // [R11]
            st_next.locked = 1'b0;
            st_next.lock_cnt = st_reg.clock_mode_reg[pcmc_pkg::PCMC_CNT_MSB:pcmc_pkg::PCMC_CNT_LSB];
        end else if (!st_reg.stable) begin // [R9]
            st_next.locked = 1'b0;
        end else if (st_reg.lock_cnt != 8'h00) begin // [R10]
            if (lock_tick) begin
                st_next.lock_cnt = st_reg.lock_cnt - 8'h01;
            end
        end else begin
            st_next.locked = 1'b1; // [R9]
        end
        // output generation from the active source
        unique case (st_reg.src)
            pcmc_pkg::PCMC_SRC_PLL: begin
                if (pll_tick) begin
                    st_next.acc = acc_sum - {1'b0, thr}; // [R2]
                    st_next.out = ~st_reg.out;
                end else begin
                    st_next.acc = acc_sum;
                end
            end
            pcmc_pkg::PCMC_SRC_BYP: begin
                st_next.out = reference_clock_input;
            end
            default: begin
                if (ref_rise) begin
                    st_next.div_phase = ~st_reg.div_phase;
                end
                if (div_tick) begin
                    st_next.out = ~st_reg.out; // [R3]
                end
            end
        endcase
        // switch only while output is low, new source restarts its low phase
        if ((want_src != st_reg.src) && !st_reg.out) begin // [R12]
            st_next.src = want_src;
            st_next.out = 1'b0;
            st_next.acc = 18'h00000;
            st_next.div_phase = 1'b0;
        end
        // register bus: one-cycle read latency, unmapped reads give zero
        st_next.rdata = 16'h0000;
        if (bus_req.rd && cmr_hit) begin // [R4]
            st_next.rdata = st_reg.clock_mode_reg;
            st_next.rdata[pcmc_pkg::PCMC_STAT_BIT] = (st_reg.src == pcmc_pkg::PCMC_SRC_PLL);
        end
        if (bus_req.wr && cmr_hit) begin // [R8]
            st_next.clock_mode_reg = wval;
            st_next.clock_mode_reg[pcmc_pkg::PCMC_STAT_BIT] = 1'b0;
            st_next.bypass = 1'b0;
            // new ratio or new turn-on restarts acquisition
            if (!pll_on || (wval[pcmc_pkg::PCMC_MUL_MSB:pcmc_pkg::PCMC_MUL_LSB] != mul_f) ||
                (wval[pcmc_pkg::PCMC_HALF_BIT] != half_f)) begin // [R9]
                st_next.locked = 1'b0;
                st_next.lock_cnt = wval[pcmc_pkg::PCMC_CNT_MSB:pcmc_pkg::PCMC_CNT_LSB];
            end
        end
        // straps are caught by the clock while device reset is held low
        if (!device_reset_n || st_reg.init_pending) begin // [R5] [R8]
            st_next.clock_mode_reg = strap_value(mode_strap);
            st_next.clock_mode_reg[pcmc_pkg::PCMC_STAT_BIT] = 1'b0;
            st_next.bypass = ({mode_strap.a, mode_strap.b, mode_strap.c} == pcmc_pkg::PCMC_STRAP_BYPASS); // [R7]
            st_next.locked = 1'b0;
            st_next.lock_cnt = 8'h00;
            st_next.init_pending = 1'b0;
        end
    end

    // ====================================================================
    // state register; async reset gives constants only, straps come a cycle later
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{clock_mode_reg: pcmc_pkg::PCMC_RST_DIV2, rdata: 16'h0000, ref_q: 1'b0,
                        period_cnt: 16'h0000, period: 16'h0000, stable: 1'b0, prescale: 4'h0,
                        lock_cnt: 8'h00, locked: 1'b0, acc: 18'h00000, div_phase: 1'b0, out: 1'b0,
                        src: pcmc_pkg::PCMC_SRC_DIV, bypass: 1'b0, init_pending: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;
    assign master_clock_output = st_reg.out;
    assign pll_locked = st_reg.locked;

    // ====================================================================
    // assertions
    AST_STRAP_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // [R5] [R6] [R7]
        !device_reset_n |=> (st_reg.clock_mode_reg == ($past(strap_value(mode_strap)) & 16'hFFFE)))
        else $error("mode register not loaded from straps");
    AST_READ_BACK: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
        (bus_req.rd && cmr_hit && !bus_req.wr) |=>
        (bus_rdata[15:1] == $past(st_reg.clock_mode_reg[15:1])))
        else $error("mode register read-back wrong");
    AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
        (bus_req.rd && !cmr_hit) |=> (bus_rdata == 16'h0000))
        else $error("unmapped read not zero");
    AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
        (bus_req.wr && cmr_hit && device_reset_n && !st_reg.init_pending) |=>
        (st_reg.clock_mode_reg[15:1] == $past(bus_req.wdata[15:1])))
        else $error("mode register write lost");
    AST_PLL_NEEDS_LOCK: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
        $changed(st_reg.src) && (st_reg.src == pcmc_pkg::PCMC_SRC_PLL) |-> $past(st_reg.locked))
        else $error("switched to loop clock before lock");
    AST_OFF_UNLOCKS: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
        (!pll_on && device_reset_n) |=> !pll_locked)
        else $error("lock held with loop off");
    AST_LOCK_AFTER_TIMER: assert property (@(posedge mclk) disable iff (!rst_n) // [R9] [R10]
        $rose(pll_locked) |-> ($past(st_reg.lock_cnt) == 8'h00) && $past(st_reg.stable))
        else $error("lock before timer expiry");
    AST_SWITCH_LOW: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
        $changed(st_reg.src) |-> !$past(master_clock_output) && !master_clock_output)
        else $error("source switched during a high phase");
    AST_DIV2_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
        (st_reg.src == pcmc_pkg::PCMC_SRC_DIV && want_src == pcmc_pkg::PCMC_SRC_DIV && ref_rise &&
         mul_f != pcmc_pkg::PCMC_MUL_DIV4) |=> (master_clock_output != $past(master_clock_output)))
        else $error("divide-by-two output missed an edge");
    AST_PLL_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_n) // [R1] [R2]
        (st_reg.src == pcmc_pkg::PCMC_SRC_PLL && want_src == pcmc_pkg::PCMC_SRC_PLL && pll_tick) |=>
        (master_clock_output != $past(master_clock_output)))
        else $error("loop output missed an edge");
    // bypass hands the sampled reference straight through, one cycle late
    AST_BYPASS_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
        (st_reg.src == pcmc_pkg::PCMC_SRC_BYP && want_src == pcmc_pkg::PCMC_SRC_BYP) |=>
        (master_clock_output == $past(reference_clock_input)))
        else $error("bypass output not following reference");
    COV_LOCK: cover property (@(posedge mclk) disable iff (!rst_n) $rose(pll_locked));
    COV_TO_PLL: cover property (@(posedge mclk) disable iff (!rst_n)
        $changed(st_reg.src) && st_reg.src == pcmc_pkg::PCMC_SRC_PLL);
    COV_BYPASS: cover property (@(posedge mclk) disable iff (!rst_n) st_reg.src == pcmc_pkg::PCMC_SRC_BYP);
    COV_DIV4: cover property (@(posedge mclk) disable iff (!rst_n)
        st_reg.src == pcmc_pkg::PCMC_SRC_DIV && mul_f == pcmc_pkg::PCMC_MUL_DIV4 && div_tick);
endmodule // pcmc_clock_gen

//--- sim/pcmc_ref_source.sv
`timescale 1ns/1ps
// ====================================================================
// reference clock source facing the clock generator
module pcmc_ref_source (
    input wire logic run,
    input wire logic [15:0] half_cycles,
    output logic reference_clock_input
);
    // free-running square wave while enabled, parked low when stopped
    // odd offset keeps every edge away from the mclk edges, so sampling is unambiguous
    initial begin
        reference_clock_input = 1'h0;
        #37;
        forever begin
            if (run) begin
                #(half_cycles * 100) reference_clock_input = ~reference_clock_input;
            end else begin
                reference_clock_input = 1'h0;
                #100;
            end
        end
    end
endmodule // pcmc_ref_source

//--- sim/pcmc_clock_gen_test.sv
`timescale 1ns/1ps
// ====================================================================
// self-checking bench for the clock mode generator
module pcmc_clock_gen_test;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic device_reset_n = 1'h1;
    pcmc_pkg::pcmc_strap_s mode_strap = '0;
    pcmc_pkg::pcmc_bus_req_s bus_req = '0;
    logic reference_clock_input;
    logic [15:0] bus_rdata;
    logic master_clock_output;
    logic pll_locked;
    logic [15:0] rd;
    logic armed = 1'h0;
    logic prev_out = 1'h0;
    int mismatches = 0;
    int cmp_count = 0;
    int run_len = 0;
    int n0;
    int n1;
    logic [2:0] pats [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5, 3'h3};
    logic [15:0] vals [8] = '{16'h0000, 16'h9007, 16'h4007, 16'h1007, 16'hF007, 16'h0000, 16'hF000, 16'h0000};

    // ====================================================================
    // clock, design and reference source
    always #50 mclk = ~mclk;
    pcmc_clock_gen pcmc_clock_gen_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .device_reset_n(device_reset_n),
        .mode_strap(mode_strap),
        .reference_clock_input(reference_clock_input),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .master_clock_output(master_clock_output),
        .pll_locked(pll_locked)
    );
    pcmc_ref_source pcmc_ref_source_inst (
        .run(1'h1),
        .half_cycles(16'h0028),
        .reference_clock_input(reference_clock_input)
    );

    // ====================================================================
    // checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // phase-length watch: a clipped high or low phase shows as a very short run
    always @(posedge mclk) begin
        if (armed && master_clock_output !== prev_out) begin
            check(16'(run_len >= 3), 16'h0001);
            run_len = 0;
        end else begin
            run_len++;
        end
        prev_out = master_clock_output;
    end

    // ====================================================================
    // register bus and waiting helpers
    task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk) bus_req <= '{a, d, 1'h1, 1'h0};
        @(posedge mclk) bus_req <= '0;
    endtask
    // data stand only in the cycle after the taken read, then fall to zero
    task automatic bus_read(input logic [15:0] a);
        @(posedge mclk) bus_req <= '{a, 16'h0000, 1'h0, 1'h1};
        @(posedge mclk) bus_req <= '0;
        #1 rd = bus_rdata;
        @(posedge mclk) #1 check(bus_rdata, 16'h0000);
    endtask
    // bounded wait for lock, returns cycles spent
    task automatic wait_lock(output int n);
        n = 0;
        while (pll_locked !== 1'h1 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 5000) begin
            mismatches++;
            test_done();
        end
    endtask
    // start counting windows mid-period of the reference, away from its rising edge
    task automatic wait_ref_fall();
        int n;
        n = 0;
        while (!(reference_clock_input === 1'h1) && n < 200) begin
            @(posedge mclk);
            n++;
        end
        while (reference_clock_input === 1'h1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic count_toggles(input int cyc, output int n);
        logic prev;
        prev = master_clock_output;
        n = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #1;
            if (master_clock_output !== prev) n++;
            prev = master_clock_output;
        end
    endtask

    // ====================================================================
    // scenarios
    task automatic strap_scan();
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) device_reset_n <= 1'h0;
            mode_strap <= pcmc_pkg::pcmc_strap_s'(pats[i]);
            repeat (3) @(posedge mclk);
            device_reset_n <= 1'h1;
            repeat (2) @(posedge mclk);
            bus_read(pcmc_pkg::PCMC_CMR_ADDR);
            check({rd[15:1], 1'h0}, {vals[i][15:1], 1'h0});
        end
    endtask
    // status bit is read-only, unmapped places neither store nor answer
    task automatic reg_access();
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'hF001);
        bus_write(16'h0059, 16'h1234);
        bus_read(pcmc_pkg::PCMC_CMR_ADDR);
        check(rd, 16'hF000);
        bus_read(16'h0059);
        check(rd, 16'h0000);
    endtask
    // times ten from a period of 80 cycles: half period of 4 cycles
    task automatic pll_check();
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'h9006);
        wait_lock(n0);
        repeat (200) @(posedge mclk);
        bus_read(pcmc_pkg::PCMC_CMR_ADDR);
        check(rd, 16'h9007);
        wait_ref_fall();
        count_toggles(320, n0);
        check(16'(n0 >= 76 && n0 <= 84), 16'h0001);
    endtask
    // a lock count of 16 adds 256 cycles; acquisition phase varies up to a period
    task automatic lock_timer_check();
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'h0000);
        repeat (10) @(posedge mclk);
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'h1006);
        wait_lock(n0);
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'h0000);
        repeat (10) @(posedge mclk);
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, 16'h1086);
        wait_lock(n1);
        check(16'((n1 - n0) >= 156 && (n1 - n0) <= 356), 16'h0001);
    endtask
    // divider setting with loop off: toggles counted over 640 cycles, eight reference periods
    task automatic divider_check(input logic [15:0] val, input int exp);
        bus_write(pcmc_pkg::PCMC_CMR_ADDR, val);
        repeat (200) @(posedge mclk);
        check({15'h0000, pll_locked}, 16'h0000);
        bus_read(pcmc_pkg::PCMC_CMR_ADDR);
        check(rd, val);
        wait_ref_fall();
        count_toggles(640, n0);
        check(16'(n0), 16'(exp));
    endtask

    // ====================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        strap_scan();
        armed = 1'h1;
        reg_access();
        pll_check();
        lock_timer_check();
        divider_check(16'h0000, 8);
        divider_check(16'hF000, 4);
        test_done();
    end
endmodule // pcmc_clock_gen_test
